/* File: core/overlap_seq_pkg.sv */
package overlap_seq_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int MIN_OFF_NS    = 400;
  localparam int MIN_OFF_CYC   = (MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEW_TICK_NS  = 1000;
  localparam int SLEW_TICK_CYC = SLEW_TICK_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // voltage scale, target in units of 0.1 mV
  // ----------------------------------------------------------------
  localparam int            TGT_W       = 16;
  localparam int            OFS_W       = 13;
  localparam logic [15:0]   DAC_BASE    = 16'h09C4;  // 0.2500 V
  localparam logic [15:0]   DAC_STEP    = 16'h0032;  // 0.0050 V
  localparam logic [15:0]   SLEW_STEP   = 16'h0064;  // 10 mV per tick
  localparam logic [16:0]   GND_LIMIT   = 17'h007CF; // 199.9 mV, below 200 mV
  localparam logic [7:0]    BOOT_CODE   = 8'h3D;
  localparam logic [7:0]    CODE_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  localparam int            MAX_PHASES  = 3;
  localparam int            TIME_W      = 12;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_ON   = 2'b01,
    ST_OFF  = 2'b11
  } seq_state_t;

endpackage

/* File: core/phase_timer.sv */
`timescale 1ns/1ps
module phase_timer #(
  parameter int WIDTH = 12
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             start_i,
  input  wire logic [WIDTH-1:0] load_i,
  output logic                  done_o
);

  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (start_i) begin
      // a zero load still gives one cycle
      cnt_next = (load_i == '0) ? WIDTH'(1) : load_i;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - WIDTH'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done_o = (cnt_reg == WIDTH'(1)) && !start_i;

endmodule

/* File: core/target_gen.sv */
`timescale 1ns/1ps
module target_gen
  import overlap_seq_pkg::*;
#(
  parameter int TICK_CYC = SLEW_TICK_CYC
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic [7:0]              code_i,
  input  wire logic signed [OFS_W-1:0] ofs_i,
  output logic [TGT_W-1:0]             target_o,
  output logic                         settled_o
);

  logic [15:0]       div_reg;
  logic [15:0]       div_next;
  logic [TGT_W-1:0]  ramp_reg;
  logic [TGT_W-1:0]  ramp_next;
  logic [TGT_W-1:0]  target_reg;
  logic [TGT_W-1:0]  target_next;
  logic [TGT_W-1:0]  dac_final;
  logic              tick;
  logic signed [16:0] ofs_ext;
  logic signed [16:0] ofs_clip;
  logic signed [16:0] sum;

  // ----------------------------------------------------------------
  // code to voltage
  // ----------------------------------------------------------------
  always_comb begin
    if (code_i == 8'h00) begin
      dac_final = '0;
    end else begin
      dac_final = DAC_BASE + 16'((16'(code_i) - 16'h0001) * DAC_STEP);
    end
  end

  // ----------------------------------------------------------------
  // slew ramp
  // ----------------------------------------------------------------
  always_comb begin
    tick      = (div_reg == 16'(TICK_CYC - 1));
    div_next  = tick ? 16'h0000 : div_reg + 16'h0001;
    ramp_next = ramp_reg;
    // ramp from zero at reset, never a step
    if (tick) begin
      if (dac_final > ramp_reg) begin
        ramp_next = (dac_final - ramp_reg > SLEW_STEP) ? ramp_reg + SLEW_STEP : dac_final;
      end else if (dac_final < ramp_reg) begin
        ramp_next = (ramp_reg - dac_final > SLEW_STEP) ? ramp_reg - SLEW_STEP : dac_final;
      end
    end
  end

  // ----------------------------------------------------------------
  // ground offset, clamped
  // ----------------------------------------------------------------
  always_comb begin
    ofs_ext  = 17'(ofs_i);
    ofs_clip = ofs_ext;
    if (ofs_ext > $signed(GND_LIMIT)) begin
      ofs_clip = $signed(GND_LIMIT);
    end else if (ofs_ext < -$signed(GND_LIMIT)) begin
      ofs_clip = -$signed(GND_LIMIT);
    end
    sum         = $signed({1'b0, ramp_reg}) + ofs_clip;
    target_next = (sum < 0) ? '0 : sum[TGT_W-1:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg    <= '0;
      ramp_reg   <= '0;
      target_reg <= '0;
    end else begin
      div_reg    <= div_next;
      ramp_reg   <= ramp_next;
      target_reg <= target_next;
    end
  end

  assign target_o  = target_reg;
  assign settled_o = (ramp_reg == dac_final);

endmodule

/* File: core/multiphase_overlap_sequencer.sv */
`timescale 1ns/1ps
module multiphase_overlap_sequencer
  import overlap_seq_pkg::*;
#(
  parameter int          PHASES    = MAX_PHASES,
  parameter int          TW        = TIME_W,
  parameter logic [7:0]  BOOT      = BOOT_CODE,
  parameter int          TICK_CYC  = SLEW_TICK_CYC
) (
  // clock and reset
  input  wire logic                    CORE_CLK_I,
  input  wire logic                    RST_I,
  // configuration and timing
  input  wire logic [1:0]              PHASE_CNT_I,
  input  wire logic [TW-1:0]           MASTER_ON_I,
  // comparators and current sense
  input  wire logic                    OUT_ABOVE_I,
  input  wire logic                    ERR_CMP_I,
  input  wire logic [PHASES-1:0]       VALLEY_ILIM_I,
  // voltage code and power state
  input  wire logic [7:0]              CODE_I,
  input  wire logic                    CODE_WR_I,
  input  wire logic                    PULSE_SKIP_STATE_TWO_I,
  input  wire logic                    PULSE_SKIP_STATE_THREE_I,
  input  wire logic signed [OFS_W-1:0] GROUND_SENSE_INPUT_I,
  // switch drivers
  output logic [PHASES-1:0]            HS_ON_O,
  output logic [PHASES-1:0]            LS_ON_O,
  // status and target
  output logic                         OVERLAP_O,
  output logic                         INTEG_SHORT_O,
  output logic [TGT_W-1:0]             REGULATION_TARGET_O
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  seq_state_t        state_reg;
  seq_state_t        state_next;
  logic [PHASES-1:0] hs_reg;
  logic [PHASES-1:0] hs_next;
  logic [PHASES-1:0] ls_reg;
  logic [PHASES-1:0] ls_next;
  logic [1:0]        last_reg;
  logic [1:0]        last_next;
  logic              overlap_reg;
  logic              overlap_next;
  logic [7:0]        code_reg;
  logic [7:0]        code_next;
  logic              integ_off_reg;
  logic              integ_off_next;
  logic              err_prev_reg;

  logic [PHASES-1:0] active;
  logic [1:0]        follow_ph;
  logic              ilim_sel;
  logic [TW-1:0]     ovl_on;
  logic              on_start;
  logic [TW-1:0]     on_load;
  logic              on_done;
  logic              off_start;
  logic              off_done;
  logic              settled;
  logic              err_edge;
  logic              pulse_skip;
  logic              code_change;

  // ----------------------------------------------------------------
  // phase helpers
  // ----------------------------------------------------------------
  for (genvar i = 0; i < PHASES; i++) begin : g_active
    assign active[i] = (2'(i) < PHASE_CNT_I);
  end

  always_comb begin
    follow_ph = (last_reg + 2'h1 >= PHASE_CNT_I) ? 2'h0 : last_reg + 2'h1;
    ilim_sel  = VALLEY_ILIM_I[follow_ph];
    // shared on-time; trimmed by a third only when three phases overlap
    if (PHASE_CNT_I == 2'h3) begin
      ovl_on = MASTER_ON_I - TW'(MASTER_ON_I / TW'(3));
    end else begin
      ovl_on = MASTER_ON_I;
    end
  end

  // ----------------------------------------------------------------
  // switching sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next   = state_reg;
    hs_next      = hs_reg;
    last_next    = last_reg;
    overlap_next = overlap_reg;
    on_start     = 1'b0;
    on_load      = MASTER_ON_I;
    off_start    = 1'b0;
    unique case (state_reg)
      ST_WAIT: begin
        // only the next phase's valley over-limit is checked, and it holds off every phase
        if (!OUT_ABOVE_I && !ilim_sel) begin
          on_start   = 1'b1;
          state_next = ST_ON;
          if (overlap_reg) begin
            hs_next = active;
            on_load = ovl_on;
          end else begin
            hs_next   = PHASES'(1) << follow_ph;
            last_next = follow_ph;
          end
        end
      end
      ST_ON: begin
        if (on_done) begin
          hs_next    = '0;
          off_start  = 1'b1;
          state_next = ST_OFF;
        end
      end
      ST_OFF: begin
        if (off_done) begin
          if (OUT_ABOVE_I) begin
            // last single phase kept, so rotation resumes after it
            overlap_next = 1'b0;
            state_next   = ST_WAIT;
          end else if (ilim_sel || PHASE_CNT_I < 2'h2) begin
            state_next = ST_WAIT;
          end else begin
            overlap_next = 1'b1;
            hs_next      = active;
            on_load      = ovl_on;
            on_start     = 1'b1;
            state_next   = ST_ON;
          end
        end
      end
      default: begin
        hs_next    = '0;
        state_next = ST_WAIT;
      end
    endcase
    ls_next = active & ~hs_next;
  end

  // ----------------------------------------------------------------
  // voltage code and integrator gating
  // ----------------------------------------------------------------
  always_comb begin
    pulse_skip  = PULSE_SKIP_STATE_TWO_I || PULSE_SKIP_STATE_THREE_I;
    code_change = CODE_WR_I && (CODE_I != code_reg);
    code_next   = CODE_WR_I ? CODE_I : code_reg;
    err_edge    = (ERR_CMP_I != err_prev_reg);
    integ_off_next = integ_off_reg;
    // a new transition wins over a release in the same cycle
    if (code_change && pulse_skip) begin
      integ_off_next = 1'b1;
    end else if (integ_off_reg && settled && err_edge) begin
      integ_off_next = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      state_reg     <= ST_WAIT;
      hs_reg        <= '0;
      ls_reg        <= '0;
      last_reg      <= 2'h0;
      overlap_reg   <= 1'b0;
      code_reg      <= BOOT;
      integ_off_reg <= 1'b0;
      err_prev_reg  <= 1'b0;
    end else begin
      state_reg     <= state_next;
      hs_reg        <= hs_next;
      ls_reg        <= ls_next;
      last_reg      <= last_next;
      overlap_reg   <= overlap_next;
      code_reg      <= code_next;
      integ_off_reg <= integ_off_next;
      err_prev_reg  <= ERR_CMP_I;
    end
  end

  // ----------------------------------------------------------------
  // timers and target
  // ----------------------------------------------------------------
  phase_timer #(
    .WIDTH   (TW)
  ) u_on_timer (
    .clk_i   (CORE_CLK_I),
    .rst_i   (RST_I),
    .start_i (on_start),
    .load_i  (on_load),
    .done_o  (on_done)
  );

  phase_timer #(
    .WIDTH   (TW)
  ) u_off_timer (
    .clk_i   (CORE_CLK_I),
    .rst_i   (RST_I),
    .start_i (off_start),
    .load_i  (TW'(MIN_OFF_CYC)),
    .done_o  (off_done)
  );

  target_gen #(
    .TICK_CYC  (TICK_CYC)
  ) u_target (
    .clk_i     (CORE_CLK_I),
    .rst_i     (RST_I),
    .code_i    (code_reg),
    .ofs_i     (GROUND_SENSE_INPUT_I),
    .target_o  (REGULATION_TARGET_O),
    .settled_o (settled)
  );

  assign HS_ON_O       = hs_reg;
  assign LS_ON_O       = ls_reg;
  assign OVERLAP_O     = overlap_reg;
  assign INTEG_SHORT_O = integ_off_reg;

endmodule

/* File: verif/overlap_seq_monitor.sv */
`timescale 1ns/1ps
module overlap_seq_monitor
  import overlap_seq_pkg::*;
#(
  parameter int         PHASES = MAX_PHASES,
  parameter logic [7:0] BOOT   = BOOT_CODE
) (
  // watched ports
  input wire logic                    CORE_CLK_I,
  input wire logic                    RST_I,
  input wire logic [1:0]              PHASE_CNT_I,
  input wire logic                    OUT_ABOVE_I,
  input wire logic                    ERR_CMP_I,
  input wire logic [PHASES-1:0]       VALLEY_ILIM_I,
  input wire logic [7:0]              CODE_I,
  input wire logic                    CODE_WR_I,
  input wire logic                    PULSE_SKIP_STATE_TWO_I,
  input wire logic                    PULSE_SKIP_STATE_THREE_I,
  input wire logic signed [OFS_W-1:0] GROUND_SENSE_INPUT_I,
  input wire logic [PHASES-1:0]       HS_ON_O,
  input wire logic                    OVERLAP_O,
  input wire logic                    INTEG_SHORT_O,
  input wire logic [TGT_W-1:0]        REGULATION_TARGET_O
);
  logic [PHASES-1:0] act;
  logic [7:0]        code_reg;
  logic [7:0]        code_next;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  assign act = PHASES'((1 << PHASE_CNT_I) - 1);
  // own copy of the held code, so only changing writes count
  always_comb begin
    code_next = CODE_WR_I ? CODE_I : code_reg;
  end
  always_ff @(posedge CORE_CLK_I) begin
    code_reg <= RST_I ? BOOT : code_next;
  end
  a_fire_cause: assert property (
    (HS_ON_O != '0) && ($past(HS_ON_O) == '0) |-> !$past(OUT_ABOVE_I) && !$past(&VALLEY_ILIM_I))
    else $error("phase fired without demand or under valley limit");
  a_single_onehot: assert property (
    !$onehot0(HS_ON_O) |-> ##[0:1] OVERLAP_O) else $error("two phases on outside overlap");
  a_overlap_all: assert property (
    OVERLAP_O && (HS_ON_O != '0) |-> HS_ON_O == act) else $error("overlap not on all phases");
  a_overlap_cfg: assert property (
    OVERLAP_O |-> PHASE_CNT_I >= 2'h2) else $error("overlap with one phase");
  a_overlap_exit: assert property (
    $fell(OVERLAP_O) |-> ($past(OUT_ABOVE_I) || $past(OUT_ABOVE_I, 2)) && HS_ON_O == '0)
    else $error("overlap left while output low");
  a_short_set: assert property (
    CODE_WR_I && CODE_I != code_reg && (PULSE_SKIP_STATE_TWO_I || PULSE_SKIP_STATE_THREE_I)
    |=> INTEG_SHORT_O) else $error("integrator not shorted on code change");
  a_short_clear: assert property (
    $fell(INTEG_SHORT_O) |-> ($past(ERR_CMP_I) != $past(ERR_CMP_I, 2)
    || $past(ERR_CMP_I, 2) != $past(ERR_CMP_I, 3)) && $stable(REGULATION_TARGET_O))
    else $error("integrator released early");
  a_target_reset: assert property (disable iff (1'b0)
    RST_I |=> REGULATION_TARGET_O == '0) else $error("target not zero after reset");
  a_target_slew: assert property (
    !$past(RST_I) && $past(GROUND_SENSE_INPUT_I, 3) == GROUND_SENSE_INPUT_I
    |-> REGULATION_TARGET_O <= $past(REGULATION_TARGET_O) + SLEW_STEP)
    else $error("target stepped faster than slew");
endmodule
bind multiphase_overlap_sequencer overlap_seq_monitor #(.PHASES(PHASES), .BOOT(BOOT)) chk (
  .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .PHASE_CNT_I(PHASE_CNT_I),
  .OUT_ABOVE_I(OUT_ABOVE_I), .ERR_CMP_I(ERR_CMP_I), .VALLEY_ILIM_I(VALLEY_ILIM_I),
  .CODE_I(CODE_I), .CODE_WR_I(CODE_WR_I), .PULSE_SKIP_STATE_TWO_I(PULSE_SKIP_STATE_TWO_I),
  .PULSE_SKIP_STATE_THREE_I(PULSE_SKIP_STATE_THREE_I), .HS_ON_O(HS_ON_O),
  .GROUND_SENSE_INPUT_I(GROUND_SENSE_INPUT_I), .OVERLAP_O(OVERLAP_O),
  .INTEG_SHORT_O(INTEG_SHORT_O), .REGULATION_TARGET_O(REGULATION_TARGET_O));

/* File: verif/regulation_model.sv */
`timescale 1ns/1ps
module regulation_model (
  input  wire logic       clk_i,
  input  wire logic       demand_i,
  input  wire logic       heavy_i,
  input  wire logic [2:0] hs_i,
  output logic            above_o,
  output logic            err_o
);
  logic hs_any_reg = 1'b0;
  initial above_o = 1'b1;
  initial err_o = 1'b0;
  // heavy load keeps the output low after a pulse, forcing overlap
  always @(posedge clk_i) begin
    hs_any_reg <= |hs_i;
    if (demand_i) begin
      above_o <= 1'b0;
    end else if (hs_any_reg && !(|hs_i) && !heavy_i) begin
      above_o <= 1'b1;
      err_o   <= ~err_o;
    end
  end
endmodule

/* File: verif/test_multiphase_overlap_sequencer.sv */
`timescale 1ns/1ps
module test_multiphase_overlap_sequencer;
  import overlap_seq_pkg::*;
  typedef struct packed {
    logic [7:0]  code;
    logic [12:0] ofs;
    logic [15:0] tgt;
  } row_t;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [1:0]         cnt = 2'h3;
  logic [7:0]         code = 8'h00;
  logic               wr = 1'b0;
  logic               ps2 = 1'b0;
  logic               ps3 = 1'b0;
  logic signed [12:0] ofs = 13'h0000;
  logic [2:0]         ilim = 3'h0;
  logic               demand = 1'b0;
  logic               heavy = 1'b0;
  logic [2:0]         hs;
  logic [2:0]         ls;
  logic               ov;
  logic               sh;
  logic [15:0]        tgt;
  logic               above;
  logic               err;
  int                 err_total = 0;
  int                 n_tests = 0;
  int                 cyc = 0;
  int                 i;
  // code and offset beside the target they settle to; rows 5 and 6 hit the clamp, the last the floor
  row_t rows [8] = '{'{8'h00, 13'h0000, 16'h0000}, '{8'h01, 13'h0000, 16'h09C4},
    '{8'h02, 13'h0000, 16'h09F6}, '{8'h0B, 13'h0000, 16'h0BB8}, '{8'hFF, 13'h0000, 16'h3B60},
    '{8'h01, 13'h0BB8, 16'h1193}, '{8'h01, 13'h1448, 16'h01F5}, '{8'h00, 13'h1E0C, 16'h0000}};
  always #12.5 clk = ~clk;
  multiphase_overlap_sequencer #(.TICK_CYC(2)) dut (
    .CORE_CLK_I(clk), .RST_I(rst), .PHASE_CNT_I(cnt), .MASTER_ON_I(12'h01E),
    .OUT_ABOVE_I(above), .ERR_CMP_I(err), .VALLEY_ILIM_I(ilim), .CODE_I(code),
    .CODE_WR_I(wr), .PULSE_SKIP_STATE_TWO_I(ps2), .PULSE_SKIP_STATE_THREE_I(ps3),
    .GROUND_SENSE_INPUT_I(ofs), .HS_ON_O(hs), .LS_ON_O(ls), .OVERLAP_O(ov),
    .INTEG_SHORT_O(sh), .REGULATION_TARGET_O(tgt));
  regulation_model far (.clk_i(clk), .demand_i(demand), .heavy_i(heavy), .hs_i(hs),
    .above_o(above), .err_o(err));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic meas(input logic [2:0] pat, input int w, input logic o);
    int k;
    k = 0;
    @(negedge clk);
    while (hs === 3'h0 && k < 300) begin
      k++;
      @(negedge clk);
    end
    chk("phase pattern", 16'(pat), 16'(hs));
    chk("overlap flag", 16'(o), 16'(ov));
    // low side covers every configured phase whose high side is off
    chk("low side", 16'(3'((4'h1 << cnt) - 4'h1) & ~pat), 16'(ls));
    k = 0;
    while (hs !== 3'h0 && k < 300) begin
      k++;
      @(negedge clk);
    end
    chk("on time", 16'(w), 16'(k));
  endtask
  // wait past min off-time, else the drop reads as an overlap request
  task automatic fire(input logic [2:0] pat, input int w);
    repeat (24) @(posedge clk);
    demand <= 1'b1;
    @(posedge clk);
    demand <= 1'b0;
    meas(pat, w, 1'b0);
  endtask
  task automatic setcode(input logic [7:0] c, input logic [12:0] o, input logic [15:0] t);
    int k;
    @(posedge clk);
    code <= c;
    ofs <= o;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    k = 0;
    while (tgt !== t && k < 900) begin
      k++;
      @(negedge clk);
    end
    chk("target", t, tgt);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test;
    end
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("target at release", 16'h0000, tgt);
    repeat (10) @(negedge clk);
    chk("ramp midway", 16'h0001, 16'(tgt > 16'h0000 && tgt < 16'h157C));
    setcode(BOOT_CODE, 13'h0000, 16'h157C);
    for (i = 0; i < 8; i++) begin
      setcode(rows[i].code, rows[i].ofs, rows[i].tgt);
    end
    fire(3'h2, 30);
    fire(3'h4, 30);
    fire(3'h1, 30);
    fire(3'h2, 30);
    @(posedge clk);
    heavy <= 1'b1;
    fire(3'h4, 30);
    meas(3'h7, 20, 1'b1);
    @(posedge clk);
    heavy <= 1'b0;
    meas(3'h7, 20, 1'b1);
    fire(3'h1, 30);
    @(posedge clk);
    cnt <= 2'h2;
    heavy <= 1'b1;
    fire(3'h2, 30);
    meas(3'h3, 30, 1'b1);
    @(posedge clk);
    heavy <= 1'b0;
    meas(3'h3, 30, 1'b1);
    repeat (24) @(posedge clk);
    ilim <= 3'h1;
    demand <= 1'b1;
    @(posedge clk);
    demand <= 1'b0;
    repeat (40) @(negedge clk);
    chk("blocked phases", 16'h0000, 16'(hs));
    @(posedge clk);
    ilim <= 3'h0;
    meas(3'h1, 30, 1'b0);
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      ps2 <= (i == 0);
      ps3 <= (i == 1);
      setcode(8'h20 + 8'(i), 13'h0000, 16'h0FD2 + 16'(i * 50));
      chk("short held", 16'h0001, 16'(sh));
      fire(3'h2 >> i, 30);
      repeat (4) @(negedge clk);
      chk("short cleared", 16'h0000, 16'(sh));
      setcode(8'h20 + 8'(i), 13'h0000, 16'h0FD2 + 16'(i * 50));
      chk("short on same code", 16'h0000, 16'(sh));
    end
    @(posedge clk);
    ps3 <= 1'b0;
    setcode(8'h01, 13'h0000, 16'h09C4);
    chk("short outside skip", 16'h0000, 16'(sh));
    finish_test;
  end
endmodule
